/* shared/prio_pkg.sv */
// Shared constants for the interrupt priority control register slice
package prio_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Structure
    localparam int REG_COUNT      = 5;   // Priority control registers
    localparam int FIELDS_PER_REG = 4;   // Priority fields per register
    localparam int SRC_COUNT      = 20;  // Sources covered by this slice
    localparam int FIELD_W        = 3;   // Width of one priority field
    localparam int ID_W           = 5;   // Width of a source number
    localparam int ADDR_W         = 12;  // APB address width
    localparam int DATA_W         = 32;  // APB data width
    localparam int REG_W          = 16;  // Implemented register width
    localparam int IDX_W          = 3;   // Width of a register word index

    ////////////////////////////////////////////////////////////////////////////
    // Byte addresses
    localparam logic [ADDR_W-1:0] OFFS_CTRL_FIVE  = 12'h000;
    localparam logic [ADDR_W-1:0] OFFS_CTRL_SIX   = 12'h004;
    localparam logic [ADDR_W-1:0] OFFS_CTRL_SEVEN = 12'h008;
    localparam logic [ADDR_W-1:0] OFFS_CTRL_EIGHT = 12'h00C;
    localparam logic [ADDR_W-1:0] OFFS_CTRL_NINE  = 12'h010;
    localparam logic [ADDR_W-1:0] OFFS_STATUS     = 12'h014;
    localparam int                WORD_SHIFT      = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Field layout: field 0 sits highest, stride of four bits
    localparam int FIELD_TOP_LSB = 12;
    localparam int FIELD_STRIDE  = 4;
    localparam int LANE_HI_LSB   = 8;    // Fields at or above go with lane 1

    ////////////////////////////////////////////////////////////////////////////
    // Priority levels
    localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h4;
    localparam logic [FIELD_W-1:0] LEVEL_OFF   = 3'h0;
    localparam logic [FIELD_W-1:0] LEVEL_MIN   = 3'h1;
    localparam logic [FIELD_W-1:0] LEVEL_MAX   = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Status register layout
    localparam int STAT_ID_LSB    = 0;
    localparam int STAT_LEVEL_LSB = 8;
    localparam int STAT_VALID_BIT = 15;

    ////////////////////////////////////////////////////////////////////////////
    // Source numbers, register order then field order
    localparam int SRC_CAPTURE8  = 0;
    localparam int SRC_CAPTURE7  = 1;
    localparam int SRC_CONV2     = 2;
    localparam int SRC_EXT1      = 3;
    localparam int SRC_TIMER4    = 4;
    localparam int SRC_COMPARE4  = 5;
    localparam int SRC_COMPARE3  = 6;
    localparam int SRC_DMA2      = 7;
    localparam int SRC_SER2_TX   = 8;
    localparam int SRC_SER2_RX   = 9;
    localparam int SRC_EXT2      = 10;
    localparam int SRC_TIMER5    = 11;
    localparam int SRC_CAN1_EV   = 12;
    localparam int SRC_CAN1_RX   = 13;
    localparam int SRC_SPI2_EV   = 14;
    localparam int SRC_SPI2_ERR  = 15;
    localparam int SRC_CAPTURE5  = 16;
    localparam int SRC_CAPTURE4  = 17;
    localparam int SRC_CAPTURE3  = 18;
    localparam int SRC_DMA3      = 19;

endpackage

/* core/prio_arbiter.sv */
// Highest-level pending source picker for the priority slice
module prio_arbiter
    import prio_pkg::*;
#(
    parameter int N   = SRC_COUNT,
    parameter int W   = FIELD_W,
    parameter int IDW = ID_W
)
(
    input  wire logic [N-1:0]   pending,
    input  wire logic [N*W-1:0] levels,
    output logic                win_valid,
    output logic [IDW-1:0]      win_id,
    output logic [W-1:0]        win_level
);

    ////////////////////////////////////////////////////////////////////////////
    // Linear scan; strict compare keeps the lowest number on a tie
    always_comb
    begin
        win_level = LEVEL_OFF;
        win_id    = '0;
        for (int i = 0; i < N; i++)
        begin
            // Level zero never beats the start value, so it never wins
            if (pending[i] && (levels[i*W +: W] > win_level))  // see (RULE11) (RULE3)
            begin
                win_level = levels[i*W +: W];
                win_id    = IDW'(i);
            end
        end
        win_valid = (win_level != LEVEL_OFF);  // see (RULE3)
    end

endmodule // prio_arbiter

/* core/interrupt_priority_regs.sv */
// Priority control registers five to nine with APB access and arbitration
// Notes on behaviour
// (RULE1) Field value seven is the top level
// (RULE2) Field value one is the lowest level
// (RULE3) Field value zero disables the source
// (RULE4) Bits 15, 11, 7, 3 read zero
// (RULE5) Fields reset to four, all read/write
// (RULE6) Register five: capture8, capture7, converter2, line1
// (RULE7) Register six: timer4, compare4, compare3, dma2
// (RULE8) Register seven: serial2 tx, rx, line2, timer5
// (RULE9) Register eight: can1 event, rx, spi2 event, error
// (RULE10) Register nine: capture5, capture4, capture3, dma3
// (RULE11) Higher level wins, two..six linear
//
// The placing of the registers and register access over APB were left to the implementer.
module interrupt_priority_regs
    import prio_pkg::*;
#(
    parameter int NREG = REG_COUNT,
    parameter int NSRC = SRC_COUNT
)
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [DATA_W-1:0]   pwdata,
    input  wire logic [DATA_W/8-1:0] pstrb,
    output logic      [DATA_W-1:0]   prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NSRC-1:0]     src_pending,
    output logic      [FIELD_W-1:0]  capture8_priority,
    output logic      [FIELD_W-1:0]  capture7_priority,
    output logic      [FIELD_W-1:0]  converter2_done_priority,
    output logic      [FIELD_W-1:0]  ext_line1_priority,
    output logic      [FIELD_W-1:0]  timer4_priority,
    output logic      [FIELD_W-1:0]  compare4_priority,
    output logic      [FIELD_W-1:0]  compare3_priority,
    output logic      [FIELD_W-1:0]  dma2_done_priority,
    output logic      [FIELD_W-1:0]  serial2_transmit_priority,
    output logic      [FIELD_W-1:0]  serial2_receive_priority,
    output logic      [FIELD_W-1:0]  ext_line2_priority,
    output logic      [FIELD_W-1:0]  timer5_priority,
    output logic      [FIELD_W-1:0]  can1_event_priority,
    output logic      [FIELD_W-1:0]  can1_rx_ready_priority,
    output logic      [FIELD_W-1:0]  spi_port2_event_priority,
    output logic      [FIELD_W-1:0]  spi_port2_error_priority,
    output logic      [FIELD_W-1:0]  capture5_priority,
    output logic      [FIELD_W-1:0]  capture4_priority,
    output logic      [FIELD_W-1:0]  capture3_priority,
    output logic      [FIELD_W-1:0]  dma3_done_priority,
    output logic                     req_valid,
    output logic      [ID_W-1:0]     req_id,
    output logic      [FIELD_W-1:0]  req_level
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Word index of an address relative to the first register
    function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] rel;
        rel = a - OFFS_CTRL_FIVE;
        return rel[WORD_SHIFT +: IDX_W];
    endfunction

    // True when the address is an aligned word inside the map
    function automatic logic word_ok(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] rel;
        rel = a - OFFS_CTRL_FIVE;
        return (rel[WORD_SHIFT-1:0] == '0) && (a <= OFFS_STATUS)
            && (a >= OFFS_CTRL_FIVE);
    endfunction

    // Pack four fields into one register image; gaps read as zero
    function automatic logic [REG_W-1:0] pack_word(input logic [4*FIELD_W-1:0] f);
        logic [REG_W-1:0] w;
        w = '0;  // see (RULE4)
        for (int j = 0; j < FIELDS_PER_REG; j++)
        begin
            w[FIELD_TOP_LSB - j*FIELD_STRIDE +: FIELD_W] =
                f[(FIELDS_PER_REG-1-j)*FIELD_W +: FIELD_W];
        end
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Storage and bus-phase wires

    logic [FIELD_W-1:0]  prio_r [NSRC];       // One field per source
    logic [DATA_W-1:0]   prdata_r;            // Read data, captured at setup
    logic [DATA_W-1:0]   prdata_nxt;          // Read value for this address
    logic                req_valid_r;         // Registered winner valid
    logic [ID_W-1:0]     req_id_r;            // Registered winner number
    logic [FIELD_W-1:0]  req_level_r;         // Registered winner level
    logic                win_valid;           // Arbiter result, combinational
    logic [ID_W-1:0]     win_id;              // Arbiter winner number
    logic [FIELD_W-1:0]  win_level;           // Arbiter winner level
    logic [NSRC*FIELD_W-1:0] levels_flat;     // Fields flattened for arbiter
    logic [REG_W-1:0]    reg_word [NREG];     // Register read images
    logic [REG_W-1:0]    status_word;         // Winner status image

    wire                 setup_phase;         // First APB cycle
    wire                 access_phase;        // Second APB cycle
    wire                 addr_hit;            // Address inside the map
    wire [IDX_W-1:0]     addr_idx;            // Word index of the address
    wire                 is_status;           // Address hits the status word
    wire                 wr_go;               // Write takes effect now
    wire                 lane_lo;             // Byte lane 0 enabled
    wire                 lane_hi;             // Byte lane 1 enabled

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign addr_hit     = word_ok(paddr);
    assign addr_idx     = word_index(paddr);
    assign is_status    = (paddr == OFFS_STATUS);
    // Status word is read-only, so a write there is silently dropped
    assign wr_go        = access_phase & pwrite & addr_hit & ~is_status;
    assign lane_lo      = pstrb[0];
    assign lane_hi      = pstrb[1];

    // Zero wait states: every access finishes in its first access cycle
    assign pready  = 1'b1;
    // Only addresses outside the map or not word aligned are flagged as errors
    assign pslverr = access_phase & ~addr_hit;
    assign prdata  = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Priority field storage

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_field
            localparam int RIDX = g / FIELDS_PER_REG;       // Owning register
            localparam int FPOS = g % FIELDS_PER_REG;       // Position in it
            localparam int LSB  = FIELD_TOP_LSB - FPOS*FIELD_STRIDE;
            wire lane_ok;                                   // Lane for this field
            wire fld_we;                                    // Field write strobe

            // Upper two fields ride byte lane 1, lower two byte lane 0
            assign lane_ok = (LSB >= LANE_HI_LSB) ? lane_hi : lane_lo;
            assign fld_we  = wr_go & lane_ok & (addr_idx == IDX_W'(RIDX));

            // Every field starts at level four after reset
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    prio_r[g] <= FIELD_RESET;  // see (RULE5)
                end
                else if (fld_we)
                begin
                    prio_r[g] <= pwdata[LSB +: FIELD_W];  // see (RULE5)
                end
            end

            // Field image handed to the arbiter as a plain level
            assign levels_flat[g*FIELD_W +: FIELD_W] = prio_r[g];  // see (RULE1) (RULE2)
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Register read images

    generate
        for (g = 0; g < NREG; g++)
        begin : g_word
            // Field order per register follows the source numbering
            assign reg_word[g] = pack_word({prio_r[g*FIELDS_PER_REG],
                                            prio_r[g*FIELDS_PER_REG+1],
                                            prio_r[g*FIELDS_PER_REG+2],
                                            prio_r[g*FIELDS_PER_REG+3]});  // see (RULE4)
        end
    endgenerate

    // Status shows the current winner as seen by the registered outputs
    always_comb
    begin
        status_word                    = '0;
        status_word[STAT_ID_LSB +: ID_W]         = req_id_r;
        status_word[STAT_LEVEL_LSB +: FIELD_W]   = req_level_r;
        status_word[STAT_VALID_BIT]              = req_valid_r;
    end

    // Read mux; bits above the register width read as zero
    always_comb
    begin
        prdata_nxt = '0;
        if (addr_hit && is_status)
        begin
            prdata_nxt = {{(DATA_W-REG_W){1'b0}}, status_word};
        end
        else if (addr_hit)
        begin
            prdata_nxt = {{(DATA_W-REG_W){1'b0}}, reg_word[addr_idx]};  // see (RULE4)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data register

    // Captured in the setup cycle, so it is stable through the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= '0;
        end
        else if (setup_phase && !pwrite)
        begin
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration

    prio_arbiter #(
        .N   (NSRC),
        .W   (FIELD_W),
        .IDW (ID_W)
    ) u_arbiter (
        .pending   (src_pending),
        .levels    (levels_flat),
        .win_valid (win_valid),
        .win_id    (win_id),
        .win_level (win_level)
    );

    // Winner registered once per clock; one cycle behind the inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_valid_r <= 1'b0;
            req_id_r    <= '0;
            req_level_r <= LEVEL_OFF;
        end
        else
        begin
            req_valid_r <= win_valid;  // see (RULE3) (RULE11)
            req_id_r    <= win_id;
            req_level_r <= win_level;
        end
    end

    assign req_valid = req_valid_r;
    assign req_id    = req_id_r;
    assign req_level = req_level_r;

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs, register five
    assign capture8_priority        = prio_r[SRC_CAPTURE8];   // see (RULE6)
    assign capture7_priority        = prio_r[SRC_CAPTURE7];   // see (RULE6)
    assign converter2_done_priority = prio_r[SRC_CONV2];      // see (RULE6)
    assign ext_line1_priority       = prio_r[SRC_EXT1];       // see (RULE6)

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs, register six
    assign timer4_priority          = prio_r[SRC_TIMER4];     // see (RULE7)
    assign compare4_priority        = prio_r[SRC_COMPARE4];   // see (RULE7)
    assign compare3_priority        = prio_r[SRC_COMPARE3];   // see (RULE7)
    assign dma2_done_priority       = prio_r[SRC_DMA2];       // see (RULE7)

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs, register seven
    assign serial2_transmit_priority = prio_r[SRC_SER2_TX];   // see (RULE8)
    assign serial2_receive_priority  = prio_r[SRC_SER2_RX];   // see (RULE8)
    assign ext_line2_priority        = prio_r[SRC_EXT2];      // see (RULE8)
    assign timer5_priority           = prio_r[SRC_TIMER5];    // see (RULE8)

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs, register eight
    assign can1_event_priority      = prio_r[SRC_CAN1_EV];    // see (RULE9)
    assign can1_rx_ready_priority   = prio_r[SRC_CAN1_RX];    // see (RULE9)
    assign spi_port2_event_priority = prio_r[SRC_SPI2_EV];    // see (RULE9)
    assign spi_port2_error_priority = prio_r[SRC_SPI2_ERR];   // see (RULE9)

    ////////////////////////////////////////////////////////////////////////////
    // Field outputs, register nine
    assign capture5_priority        = prio_r[SRC_CAPTURE5];   // see (RULE10)
    assign capture4_priority        = prio_r[SRC_CAPTURE4];   // see (RULE10)
    assign capture3_priority        = prio_r[SRC_CAPTURE3];   // see (RULE10)
    assign dma3_done_priority       = prio_r[SRC_DMA3];       // see (RULE10)

endmodule // interrupt_priority_regs

/* dv/interrupt_priority_regs_asserts.sv */
// Concurrent checks on the priority control register slice
module interrupt_priority_regs_asserts
    import prio_pkg::*;
#(
    parameter int NSRC = SRC_COUNT
)
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [DATA_W-1:0]   pwdata,
    input wire logic [DATA_W/8-1:0] pstrb,
    input wire logic [DATA_W-1:0]   prdata,
    input wire logic [NSRC-1:0]     src_pending,
    input wire logic [FIELD_W-1:0]  capture8_priority,
    input wire logic [FIELD_W-1:0]  capture7_priority,
    input wire logic [FIELD_W-1:0]  compare3_priority,
    input wire logic [FIELD_W-1:0]  dma2_done_priority,
    input wire logic [FIELD_W-1:0]  serial2_transmit_priority,
    input wire logic [FIELD_W-1:0]  spi_port2_error_priority,
    input wire logic [FIELD_W-1:0]  capture3_priority,
    input wire logic [FIELD_W-1:0]  dma3_done_priority,
    input wire logic                req_valid,
    input wire logic [ID_W-1:0]     req_id,
    input wire logic [FIELD_W-1:0]  req_level
);
    // Access-edge strobes
    wire               wr_acc = psel && penable && pwrite;
    wire               rd_acc = psel && penable && !pwrite;
    logic [DATA_W-1:0] wd_q;   // Write data one edge late

    // Delay write data so fields can be compared after the write edge
    always_ff @(posedge pclk)
    begin
        wd_q <= pwdata;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////
    // Register side
    a_spare_zero: assert property (rd_acc && paddr < OFFS_STATUS
        |-> (prdata & 32'hFFFF_8888) == '0) else $error("Spare bits read nonzero");
    a_reset_four: assert property ($rose(presetn)
        |-> capture8_priority == FIELD_RESET && dma3_done_priority == FIELD_RESET)
        else $error("Field not at reset level");
    a_five_upper: assert property (wr_acc && paddr == OFFS_CTRL_FIVE && pstrb[1]
        |=> capture8_priority == wd_q[14:12] && capture7_priority == wd_q[10:8])
        else $error("Register five upper fields wrong");
    a_six_lower: assert property (wr_acc && paddr == OFFS_CTRL_SIX && pstrb[0]
        |=> compare3_priority == wd_q[6:4] && dma2_done_priority == wd_q[2:0])
        else $error("Register six lower fields wrong");
    a_seven_upper: assert property (wr_acc && paddr == OFFS_CTRL_SEVEN && pstrb[1]
        |=> serial2_transmit_priority == wd_q[14:12]) else $error("Register seven field wrong");
    a_eight_lower: assert property (wr_acc && paddr == OFFS_CTRL_EIGHT && pstrb[0]
        |=> spi_port2_error_priority == wd_q[2:0]) else $error("Register eight field wrong");
    a_nine_lower: assert property (wr_acc && paddr == OFFS_CTRL_NINE && pstrb[0]
        |=> capture3_priority == wd_q[6:4] && dma3_done_priority == wd_q[2:0])
        else $error("Register nine lower fields wrong");

    ////////////////////////////////////////
    // Arbitration side
    a_off_never_wins: assert property (req_valid |-> req_level != LEVEL_OFF)
        else $error("Disabled level granted");
    a_top_wins: assert property (src_pending[0] && capture8_priority == LEVEL_MAX
        |=> req_valid && req_id == '0 && req_level == LEVEL_MAX) else $error("Top level lost");
    a_min_wins: assert property (src_pending == 20'h0_0002 && capture7_priority == LEVEL_MIN
        |=> req_valid && req_id == 5'h01 && req_level == LEVEL_MIN) else $error("Level one lost");

    c_write_nine: cover property (wr_acc && paddr == OFFS_CTRL_NINE);
    c_status_read: cover property (rd_acc && paddr == OFFS_STATUS);
    c_top_level: cover property (req_valid && req_level == LEVEL_MAX);
endmodule // interrupt_priority_regs_asserts

bind interrupt_priority_regs interrupt_priority_regs_asserts #(.NSRC(NSRC)) i_asserts (.*);

/* dv/interrupt_priority_regs_test.sv */
// Self-checking bench for the priority control register slice
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module interrupt_priority_regs_test import prio_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {logic [DATA_W-1:0] m; logic [DATA_W-1:0] d; logic e;} note_type;

    logic                 pclk, presetn, psel, penable, pwrite;
    logic [ADDR_W-1:0]    paddr;
    logic [DATA_W-1:0]    pwdata;
    logic [3:0]           pstrb;
    logic [SRC_COUNT-1:0] src_pending;
    wire  [DATA_W-1:0]    prdata;
    wire                  pready, pslverr, req_valid;
    wire  [ID_W-1:0]      req_id;
    wire  [FIELD_W-1:0]   req_level;
    wire  [FIELD_W-1:0]   fld [SRC_COUNT];   // Field outputs by source number
    logic [15:0]          shd [REG_COUNT];   // Expected register contents
    note_type             q [$];             // Pending expectations, oldest first
    note_type             nt;
    int                   n_mismatch, checks;
    int                   seed = 53;

    interrupt_priority_regs i_interrupt_priority_regs (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_pending(src_pending), .capture8_priority(fld[0]), .capture7_priority(fld[1]),
        .converter2_done_priority(fld[2]), .ext_line1_priority(fld[3]),
        .timer4_priority(fld[4]), .compare4_priority(fld[5]), .compare3_priority(fld[6]),
        .dma2_done_priority(fld[7]), .serial2_transmit_priority(fld[8]),
        .serial2_receive_priority(fld[9]), .ext_line2_priority(fld[10]),
        .timer5_priority(fld[11]), .can1_event_priority(fld[12]),
        .can1_rx_ready_priority(fld[13]), .spi_port2_event_priority(fld[14]),
        .spi_port2_error_priority(fld[15]), .capture5_priority(fld[16]),
        .capture4_priority(fld[17]), .capture3_priority(fld[18]),
        .dma3_done_priority(fld[19]), .req_valid(req_valid), .req_id(req_id),
        .req_level(req_level));

    ////////////////////////////////////////
    // Helpers
    task automatic end_sim();
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Expected level of a source from the shadow copy
    function automatic logic [FIELD_W-1:0] lvl(input int i);
        return shd[i / FIELDS_PER_REG][14 - 4 * (i % FIELDS_PER_REG) -: FIELD_W];
    endfunction

    // One APB transfer, expectation queued first; idle cycle after it
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [3:0] s, input logic [DATA_W-1:0] m, input logic e);
        int k;
        q.push_back({m, d, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        // A stuck slave ends the run
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            end_sim();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Write a register; only strobed lanes and implemented bits change
    task automatic wreg(input int r, input logic [DATA_W-1:0] d, input logic [3:0] s);
        xfer(1'b1, ADDR_W'(4 * r), d, s, '0, 1'b0);
        for (int b = 0; b < 2; b++)
            if (s[b])
                shd[r][8 * b +: 8] = d[8 * b +: 8] & 8'h77;
    endtask

    task automatic rdreg(input int r);
        xfer(1'b0, ADDR_W'(4 * r), {16'h0000, shd[r]}, 4'h0, '1, 1'b0);
    endtask

    task automatic chk_ports();
        for (int i = 0; i < SRC_COUNT; i++)
            `CHK(fld[i], lvl(i))
    endtask

    // Status read against a reference pick: higher level, then lower number
    task automatic rdstat();
        logic [2:0] best;
        logic [4:0] id;
        // Let a just-driven pending word land and pass the winner register first
        repeat (2) @(posedge pclk);
        best = '0;
        id = '0;
        for (int i = 0; i < SRC_COUNT; i++)
            if (src_pending[i] && lvl(i) > best)
            begin
                best = lvl(i);
                id = ID_W'(i);
            end
        if (best == LEVEL_OFF)
            xfer(1'b0, OFFS_STATUS, '0, 4'h0, 32'h0000_8000, 1'b0);
        else
            xfer(1'b0, OFFS_STATUS, {16'h0, 1'b1, 4'h0, best, 3'h0, id}, 4'h0, 32'h0000_871F, 1'b0);
    endtask

    ////////////////////////////////////////
    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Monitor: each completed transfer retires the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            if (q.size() == 0)
                `CHK(1'b1, 1'b0)
            else
            begin
                nt = q.pop_front();
                `CHK({pslverr, prdata & nt.m}, {nt.e, nt.d & nt.m})
            end
        end
    end

    // Main sequence
    initial
    begin
        int r;
        logic [DATA_W-1:0] d;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        src_pending = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < REG_COUNT; i++)
        begin
            shd[i] = 16'h4444;
            rdreg(i);
        end
        chk_ports();
        // Random writes with random lanes, then readback and arbitration
        repeat (40)
        begin
            r = $unsigned($random(seed)) % REG_COUNT;
            d = $random(seed);
            src_pending <= SRC_COUNT'($random(seed));
            wreg(r, d, 4'($random(seed)));
            rdreg(r);
            chk_ports();
            rdstat();
        end
        // Directed levels: all off, level one alone, ties at the top
        for (int i = 0; i < REG_COUNT; i++)
            wreg(i, '0, 4'hF);
        src_pending <= '1;
        rdstat();
        src_pending <= 20'h0_0002;
        wreg(0, 32'h0000_0100, 4'hF);
        rdstat();
        wreg(0, 32'h0000_7777, 4'hF);
        wreg(4, 32'h0000_7777, 4'hF);
        src_pending <= '1;
        rdstat();
        src_pending <= 20'hF_0000;
        rdstat();
        // Unmapped, misaligned and read-only places
        xfer(1'b0, 12'h018, '0, 4'h0, '1, 1'b1);
        xfer(1'b1, 12'h002, 32'h0000_1111, 4'hF, '0, 1'b1);
        xfer(1'b1, OFFS_STATUS, 32'h0000_1111, 4'hF, '0, 1'b0);
        rdreg(0);
        end_sim();
    end
endmodule // interrupt_priority_regs_test
